// file: core/tlm_pkg.sv
// package for the test loop mode controller: register map, types, constants
package tlm_pkg;
	// ======================================================
	// register map (byte addresses)
	localparam logic [11:0] TLM_CTRL_OFF = 12'h000;
	localparam logic [11:0] TLM_CMD_OFF = 12'h004;
	localparam logic [11:0] TLM_PDU_OFF = 12'h008;
	localparam logic [11:0] TLM_STAT_OFF = 12'h00c;
	localparam logic [11:0] TLM_SENT_OFF = 12'h010;
	localparam logic [11:0] TLM_PRBS_OFF = 12'h014;
	// ctrl field positions
	localparam int TLM_CTRL_CAP_A = 0;
	localparam int TLM_CTRL_CAP_B = 1;
	// cmd write field positions (write strobes, self-clearing)
	localparam int TLM_CMD_OPEN_SS = 0;
	localparam int TLM_CMD_OPEN_MS = 1;
	localparam int TLM_CMD_CLOSE_SS = 2;
	localparam int TLM_CMD_CLOSE_C = 3;
	localparam int TLM_CMD_CLOSE_MS = 4;
	localparam int TLM_CMD_START = 5;
	localparam int TLM_CMD_MBIT = 6;
	localparam int TLM_CMD_REL = 7;
	localparam int TLM_CMD_DL_END = 8;
	localparam int TLM_CMD_OFS_LSB = 12;
	// reset values
	localparam logic [1:0] TLM_CTRL_RST = 2'h3;
	localparam logic [14:0] TLM_PRBS_SEED = 15'h7fff;
	localparam logic [14:0] TLM_CV_IDLE = 15'h0000;
	localparam logic [3:0] TLM_CV_NONE = 4'hf;
	localparam int TLM_PRBS_LEN = 15;
	localparam int TLM_SLOTS = 8;

	typedef enum logic [1:0] {TLM_IDLE, TLM_MODE_A, TLM_MODE_B} tlm_mode_type;

	// one downlink block as delivered by the receive chain
	typedef struct packed {
		logic valid;
		logic [2:0] slot;
		logic is_ctrl;
		logic usf_ok;
		logic crc_ok;
		logic usf_mine;
		logic [31:0] payload;
	} tlm_dl_type;

	// one uplink block word towards the transmit chain
	typedef struct packed {
		logic valid;
		logic [2:0] slot;
		logic [3:0] cv;
		logic [31:0] payload;
	} tlm_ul_type;

	// messages and requests to the protocol stack
	typedef struct packed {
		logic open_ack_c;
		logic ms_open_ack;
		logic ul_tbf_req;
	} tlm_msg_type;
endpackage

// file: core/tlm_core.sv
// test loop mode controller: loop open/close and packet test modes a and b
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module tlm_core
	import tlm_pkg::*;
#(
	parameter int PDU_W = 16
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tlm_pkg::tlm_dl_type dl_in,
	input wire logic ul_ctrl_slot,
	input wire logic [7:0] dl_slot_mask,
	input wire logic [7:0] ul_slot_mask,
	output tlm_pkg::tlm_ul_type ul_out,
	output tlm_pkg::tlm_msg_type msg_out,
	output logic llc_fwd,
	output logic ctrl_fwd,
	output logic normal_use
);
	import tlm_pkg::*;

	initial begin
		if (PDU_W < 1 || PDU_W > 16) begin
			$error("PDU_W out of range");
		end
	end

	// ======================================================
	// state
	typedef struct packed {
		logic [1:0] cap;
		logic ss_closed;
		logic ss_type_c;
		logic ms_closed;
		tlm_mode_type mode;
		logic [2:0] dl_ofs;
		logic [PDU_W-1:0] pdu_target;
		logic [PDU_W-1:0] pdu_sent;
		logic [14:0] prbs;
		logic [31:0] last_pay;
		logic [31:0] first_pay;
		logic [TLM_SLOTS-1:0][31:0] slot_pay;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		tlm_ul_type ul;
		tlm_msg_type msg;
		logic llc_fwd;
		logic ctrl_fwd;
		logic normal_use;
	} tlm_state_type;

	tlm_state_type s_q, s_d;

	// ======================================================
	// slot index helpers
	// ordinal of a downlink slot counted from the first active slot at/after the offset
	function automatic logic [3:0] dl_ordinal(input logic [2:0] sl, input logic [2:0] ofs,
			input logic [7:0] msk);
		logic [3:0] n;
		logic [2:0] t;
		n = 4'h0;
		for (int i = 0; i < TLM_SLOTS; i++) begin
			t = 3'(ofs + 3'(i));
			if (t == sl) begin
				break;
			end
			if (msk[t]) begin
				n = 4'(n + 4'h1);
			end
		end
		return n;
	endfunction

	// ordinal of an uplink slot counted from slot 0
	function automatic logic [3:0] ul_ordinal(input logic [2:0] sl, input logic [7:0] msk);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < TLM_SLOTS; i++) begin
			if (3'(i) < sl && msk[i]) begin
				n = 4'(n + 4'h1);
			end
		end
		return n;
	endfunction

	// ======================================================
	// apb decode
	logic acc, wr, rd;
	assign acc = psel && penable && !s_q.pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;

	logic [3:0] dl_cnt, ord_dl, ord_ul;
	logic prbs_fb;
	logic [31:0] prbs_word;

	always_comb begin
		dl_cnt = 4'h0;
		for (int i = 0; i < TLM_SLOTS; i++) begin
			dl_cnt = 4'(dl_cnt + {3'h0, dl_slot_mask[i]});
		end
		ord_dl = dl_ordinal(dl_in.slot, s_q.dl_ofs, dl_slot_mask);
		ord_ul = ul_ordinal(dl_in.slot, ul_slot_mask);
		prbs_fb = s_q.prbs[14] ^ s_q.prbs[13];
		prbs_word = {s_q.prbs[14:0], s_q.prbs[14:0], s_q.prbs[1:0]};
	end

	// ======================================================
	// next state
	always_comb begin
		logic [31:0] pay;
		logic send;
		logic [3:0] src;
		pay = 32'h0000_0000;
		send = 1'b0;
		src = 4'h0;
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.msg = '0;
		s_d.ul.valid = 1'b0;
		s_d.prdata = 32'h0000_0000;

		if (acc) begin
			s_d.pready = 1'b1;
			if (rd) begin
				unique case (paddr)
					TLM_CTRL_OFF: s_d.prdata = {30'h0, s_q.cap};
					TLM_PDU_OFF: s_d.prdata = 32'(s_q.pdu_target);
					TLM_STAT_OFF: s_d.prdata = {26'h0, s_q.mode, s_q.ms_closed,
						s_q.ss_type_c, s_q.ss_closed};
					TLM_SENT_OFF: s_d.prdata = 32'(s_q.pdu_sent);
					TLM_PRBS_OFF: s_d.prdata = {17'h0, s_q.prbs};
					TLM_CMD_OFF: s_d.prdata = 32'h0000_0000;
					default: s_d.pslverr = 1'b1;
				endcase
			end
		end

		if (wr) begin
			unique case (paddr)
				TLM_CTRL_OFF: s_d.cap = pwdata[1:0];
				TLM_PDU_OFF: s_d.pdu_target = pwdata[PDU_W-1:0];
				TLM_PRBS_OFF: s_d.prbs = pwdata[14:0];
				TLM_CMD_OFF: begin
					if (pwdata[TLM_CMD_OPEN_SS] && s_q.ss_closed) begin
						s_d.ss_closed = 1'b0;
						s_d.ss_type_c = 1'b0;
						s_d.msg.open_ack_c = s_q.ss_type_c;
					end
					// an open with nothing closed falls through untouched
					if (pwdata[TLM_CMD_OPEN_MS] && s_q.ms_closed) begin
						s_d.ms_closed = 1'b0;
						s_d.msg.ms_open_ack = 1'b1;
					end
					if (pwdata[TLM_CMD_CLOSE_SS] && !s_q.ss_closed && !s_q.ms_closed) begin
						s_d.ss_closed = 1'b1;
						s_d.ss_type_c = pwdata[TLM_CMD_CLOSE_C];
					end
					if (pwdata[TLM_CMD_CLOSE_MS] && !s_q.ss_closed && !s_q.ms_closed) begin
						s_d.ms_closed = 1'b1;
					end
					if (pwdata[TLM_CMD_START] && s_q.mode == TLM_IDLE && s_q.cap != 2'h0) begin
						// capability decides; m bit only matters when both declared
						if (s_q.cap == 2'h3) begin
							s_d.mode = pwdata[TLM_CMD_MBIT] ? TLM_MODE_B : TLM_MODE_A;
						end else begin
							s_d.mode = s_q.cap[TLM_CTRL_CAP_B] ? TLM_MODE_B : TLM_MODE_A;
						end
						s_d.dl_ofs = pwdata[TLM_CMD_OFS_LSB +: 3];
						s_d.pdu_sent = '0;
						s_d.msg.ul_tbf_req = 1'b1;
					end
					if (pwdata[TLM_CMD_REL] && s_q.mode != TLM_IDLE) begin
						s_d.mode = TLM_IDLE;
					end
					if (pwdata[TLM_CMD_DL_END] && s_q.mode == TLM_MODE_B) begin
						s_d.mode = TLM_IDLE;
					end
				end
				default: ;
			endcase
		end

		// ======================================================
		// block handling
		s_d.llc_fwd = dl_in.valid && !dl_in.is_ctrl && dl_in.crc_ok &&
			s_q.mode == TLM_IDLE;
		s_d.ctrl_fwd = dl_in.valid && dl_in.is_ctrl && dl_in.crc_ok;
		s_d.normal_use = !s_q.ss_closed && !s_q.ms_closed;

		if (dl_in.valid && s_q.mode != TLM_IDLE) begin
			send = dl_in.usf_ok && dl_in.usf_mine;
			if (s_q.mode == TLM_MODE_A) begin
				// one generator step per block; later slots reuse the first word
				if (ord_ul == 4'h0) begin
					pay = prbs_word;
					s_d.first_pay = prbs_word;
					s_d.prbs = {s_q.prbs[13:0], prbs_fb};
				end else begin
					pay = s_q.first_pay;
				end
			end else begin
				if (dl_in.is_ctrl) begin
					pay = s_q.last_pay;
				end else begin
					pay = dl_in.payload;
					s_d.slot_pay[ord_dl[2:0]] = dl_in.payload;
				end
				if (dl_cnt > 4'h1) begin
					// clamp to last matched downlink ordinal
					src = (ord_ul < dl_cnt) ? ord_ul : 4'(dl_cnt - 4'h1);
					if (src != 4'h0 && !dl_in.is_ctrl && src == ord_dl) begin
						pay = dl_in.payload;
					end else if (src != 4'h0) begin
						pay = s_q.slot_pay[src[2:0]];
					end
				end // single dl slot: every ul slot carries the mode payload
				s_d.last_pay = pay;
			end
			if (send && !(s_q.mode == TLM_MODE_B && ul_ctrl_slot)) begin
				s_d.ul.valid = 1'b1;
				s_d.ul.slot = dl_in.slot;
				s_d.ul.payload = pay;
				s_d.ul.cv = TLM_CV_NONE;
				if (s_q.mode == TLM_MODE_A) begin
					s_d.pdu_sent = PDU_W'(s_q.pdu_sent + 1'b1);
					if (PDU_W'(s_q.pdu_sent + 1'b1) == s_q.pdu_target) begin
						s_d.mode = TLM_IDLE;
					end
				end
			end
		end
	end

	// ======================================================
	// registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.cap <= TLM_CTRL_RST;
			s_q.prbs <= TLM_PRBS_SEED;
			s_q.mode <= TLM_IDLE;
			s_q.normal_use <= 1'b1;
			s_q.ul.cv <= TLM_CV_NONE;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign ul_out = s_q.ul;
	assign msg_out = s_q.msg;
	assign llc_fwd = s_q.llc_fwd;
	assign ctrl_fwd = s_q.ctrl_fwd;
	assign normal_use = s_q.normal_use;

	// ======================================================
	// checks
	a_open_ss_ack: assert property (@(posedge clock) disable iff (!arst_n)
		wr && paddr == TLM_CMD_OFF && pwdata[TLM_CMD_OPEN_SS] && s_q.ss_closed
		&& s_q.ss_type_c |=> msg_out.open_ack_c && !s_q.ss_closed)
		else $error("type c open not acknowledged");
	a_open_ms_ack: assert property (@(posedge clock) disable iff (!arst_n)
		wr && paddr == TLM_CMD_OFF && pwdata[TLM_CMD_OPEN_MS] && s_q.ms_closed
		|=> msg_out.ms_open_ack && !s_q.ms_closed)
		else $error("multi-slot open not acknowledged");
	a_open_ignored: assert property (@(posedge clock) disable iff (!arst_n)
		msg_out.ms_open_ack |-> $past(s_q.ms_closed))
		else $error("acknowledge without closed loop");
	a_start_req: assert property (@(posedge clock) disable iff (!arst_n)
		msg_out.ul_tbf_req |-> $past(s_q.mode) == TLM_IDLE && s_q.mode != TLM_IDLE)
		else $error("flow request without test start");
	a_no_llc: assert property (@(posedge clock) disable iff (!arst_n)
		$past(s_q.mode) != TLM_IDLE |-> !llc_fwd)
		else $error("data forwarded during test mode");
	a_usf_gate: assert property (@(posedge clock) disable iff (!arst_n)
		ul_out.valid |-> $past(dl_in.valid && dl_in.usf_ok && dl_in.usf_mine))
		else $error("uplink without usf grant");
	a_cv_fixed: assert property (@(posedge clock) disable iff (!arst_n)
		ul_out.valid |-> ul_out.cv == TLM_CV_NONE)
		else $error("countdown value not fifteen");
	a_echo_b: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.mode == TLM_MODE_B && dl_in.valid && !dl_in.is_ctrl && dl_in.usf_ok
		&& dl_in.usf_mine && !ul_ctrl_slot && dl_cnt <= 4'h1
		|=> ul_out.valid && ul_out.payload == $past(dl_in.payload))
		else $error("mode b payload not echoed");
	a_ctrl_fwd: assert property (@(posedge clock) disable iff (!arst_n)
		dl_in.valid && dl_in.is_ctrl && dl_in.crc_ok |=> ctrl_fwd)
		else $error("control block not forwarded");
endmodule
`default_nettype wire

// file: sim/tlm_sim_model.sv
// stand-in for the test equipment: launches downlink blocks on request
`timescale 1ns/1ps
`default_nettype none
module tlm_sim_model
	import tlm_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic send,
	input wire tlm_pkg::tlm_dl_type blk,
	output tlm_pkg::tlm_dl_type dl_in
);
	// ======================================
	// block launch
	// idle fields toggle so no stale value can pass for a block
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dl_in <= '0;
		end else if (send) begin
			dl_in <= blk;
		end else begin
			dl_in <= {1'b0, ~dl_in[$bits(dl_in)-2:0]};
		end
	end
endmodule
`default_nettype wire

// file: sim/test_loop_mode_controller_bench.sv
// self-checking testbench for the test loop mode controller
`timescale 1ns/1ps
`default_nettype none
module test_loop_mode_controller_bench;
	import tlm_pkg::*;
	logic clock, arst_n, psel, penable, pwrite, pready, pslverr, send, ul_ctrl_slot, err;
	logic llc_fwd, ctrl_fwd, normal_use;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, last_pl, pw;
	logic [14:0] lf;
	logic pr_on;
	logic [7:0] dl_mask, ul_mask;
	logic [32:0] e;
	logic [32:0] expq[$];
	tlm_dl_type blk, dl_in;
	tlm_ul_type ul_out;
	tlm_msg_type msg_out;
	int fail_count, compares, cycles, n_ack_c, n_ms_ack, n_tbf, n_llc, n_ctrl;

	tlm_sim_model u_sim (.clock(clock), .arst_n(arst_n), .send(send), .blk(blk), .dl_in(dl_in));
	tlm_core u_dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dl_in(dl_in), .ul_ctrl_slot(ul_ctrl_slot),
		.dl_slot_mask(dl_mask), .ul_slot_mask(ul_mask), .ul_out(ul_out), .msg_out(msg_out),
		.llc_fwd(llc_fwd), .ctrl_fwd(ctrl_fwd), .normal_use(normal_use));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ======================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// request held until pready is seen high at a falling edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// look at pready once it has settled, then release after the sampling edge
		do @(negedge clock); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		@(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge clock);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	function automatic logic [31:0] cmd(input int b);
		return 32'h1 << b;
	endfunction

	// one downlink block; the bench model queues the uplink block it implies
	task automatic dl(input logic ctl, input logic crc, input logic mine, input logic up,
		input logic known);
		logic [31:0] pl;
		pl = $urandom;
		@(posedge clock);
		blk <= '{valid: 1'b1, slot: 3'h0, is_ctrl: ctl, usf_ok: 1'b1, crc_ok: crc,
			usf_mine: mine, payload: pl};
		send <= 1'b1;
		if (up && !ctl)
			last_pl = pl;
		pw = last_pl;
		if (pr_on) begin
			pw = {lf, lf, lf[1:0]};
			lf = {lf[13:0], lf[14] ^ lf[13]};
		end
		if (up)
			expq.push_back({known, pw});
		@(posedge clock);
		send <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// ======================================
	// monitor and timeout
	// sampled mid-cycle so registered pulses are seen settled
	always @(negedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			print_verdict();
		end
		if (arst_n === 1'b1) begin
			n_ack_c += int'(msg_out.open_ack_c === 1'b1);
			n_ms_ack += int'(msg_out.ms_open_ack === 1'b1);
			n_tbf += int'(msg_out.ul_tbf_req === 1'b1);
			n_llc += int'(llc_fwd === 1'b1);
			n_ctrl += int'(ctrl_fwd === 1'b1);
			if (ul_out.valid === 1'b1) begin
				if (expq.size() == 0) begin
					check(32'h1, 32'h0);
				end else begin
					e = expq.pop_front();
					if (e[32])
						check(ul_out.payload, e[31:0]);
					check({28'h0, ul_out.cv}, {28'h0, TLM_CV_NONE});
				end
			end
		end
	end

	// ======================================
	// main sequence
	initial begin
		{arst_n, psel, penable, pwrite, send, ul_ctrl_slot} = '0;
		{paddr, pwdata, blk, last_pl, pw, pr_on} = '0;
		lf = TLM_PRBS_SEED;
		dl_mask = 8'h01;
		ul_mask = 8'h01;
		void'($urandom(32'h9e82));
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		check({31'h0, normal_use}, 32'h1);
		rd(TLM_CTRL_OFF, 32'h3);
		rd(TLM_STAT_OFF, 32'h0);
		rd(12'h0fc, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test reset done");
		wr(TLM_CMD_OFF, cmd(TLM_CMD_OPEN_SS) | cmd(TLM_CMD_OPEN_MS));
		check(32'(n_ack_c + n_ms_ack), 32'h0);
		$display("test ignored opens done");
		wr(TLM_CMD_OFF, cmd(TLM_CMD_CLOSE_SS) | cmd(TLM_CMD_CLOSE_C));
		rd(TLM_STAT_OFF, 32'h3);
		check({31'h0, normal_use}, 32'h0);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_OPEN_SS));
		check(32'(n_ack_c), 32'h1);
		check({31'h0, normal_use}, 32'h1);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_CLOSE_MS));
		rd(TLM_STAT_OFF, 32'h4);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_OPEN_MS));
		check(32'(n_ms_ack), 32'h1);
		check(32'(n_ack_c), 32'h1);
		rd(TLM_STAT_OFF, 32'h0);
		$display("test loops done");
		wr(TLM_CTRL_OFF, 32'h1);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_START) | cmd(TLM_CMD_MBIT));
		rd(TLM_STAT_OFF, 32'h8);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_REL));
		rd(TLM_STAT_OFF, 32'h0);
		wr(TLM_CTRL_OFF, 32'h3);
		wr(TLM_PDU_OFF, 32'h3);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_START));
		check(32'(n_tbf), 32'h2);
		rd(TLM_STAT_OFF, 32'h8);
		pr_on = 1'b1;
		dl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		for (int i = 0; i < 3; i++)
			dl(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		pr_on = 1'b0;
		check(32'(n_llc), 32'h0);
		// block after the count ran out: mode over, data goes to llc again
		dl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		rd(TLM_STAT_OFF, 32'h0);
		rd(TLM_SENT_OFF, 32'h3);
		check(32'(n_llc), 32'h1);
		$display("test mode a done");
		wr(TLM_CMD_OFF, cmd(TLM_CMD_START) | cmd(TLM_CMD_MBIT));
		rd(TLM_STAT_OFF, 32'h10);
		dl(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		dl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
		dl(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		check(32'(n_ctrl), 32'h1);
		ul_ctrl_slot <= 1'b1;
		dl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		ul_ctrl_slot <= 1'b0;
		dl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		check(32'(n_llc), 32'h1);
		wr(TLM_CMD_OFF, cmd(TLM_CMD_DL_END));
		rd(TLM_STAT_OFF, 32'h0);
		$display("test mode b done");
		dl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		check(32'(n_llc), 32'h2);
		check(32'(expq.size()), 32'h0);
		$display("test idle done");
		print_verdict();
	end
endmodule
`default_nettype wire
